// ==== core/io_status_pkg.sv ====
// Package of field layouts, codes and constants for the status field bank
package io_status_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int WORD_W = 16;
	localparam int ID_W = 8;
	localparam int ADDR_W = 24;
	localparam int WIN_DISP_W = 8;

	// ----------------------------------------
	// Control window displacements (double-byte units)
	// ----------------------------------------
	localparam logic [7:0] CW_BASE = 8'h04;
	localparam logic [7:0] DISP_PROCESSOR_STATUS = 8'h05;
	localparam logic [7:0] DISP_PERIPH_STATE = 8'h06;
	localparam logic [7:0] DISP_IPS_STATE = 8'h07;
	localparam logic [7:0] DISP_ALARM_STATE = 8'h08;
	localparam logic [7:0] DISP_DISPATCH_STATE = 8'h09;
	localparam logic [7:0] DISP_RECONF_STATE = 8'h0a;
	localparam logic [7:0] DISP_PROC_SEL = 8'h0b;
	localparam logic [7:0] DISP_FUNC_STATE = 8'h0c;
	localparam logic [7:0] DISP_OPCODE = 8'h0d;
	localparam logic [7:0] DISP_OPERAND = 8'h0e;
	localparam logic [7:0] DISP_RESULT = 8'h0f;
	localparam logic [7:0] DISP_PROCESS_STATUS = 8'h10;

	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [3:0] PSTATE_IDLE = 4'h0;
	localparam logic [3:0] PSTATE_EXEC = 4'h1;
	localparam logic [3:0] FCOMP_DONE = 4'h0;
	localparam logic [3:0] FCOMP_BUSY = 4'h1;
	localparam logic [1:0] FLT_NONE = 2'h0;
	localparam logic [1:0] FLT_CONTEXT = 2'h1;
	localparam logic [1:0] FLT_PROCESS = 2'h2;
	localparam logic [1:0] FLT_PROCESSOR = 2'h3;
	localparam logic [WORD_W-1:0] RESET_WORD = 16'h0000;

	// ----------------------------------------
	// Field layouts
	// ----------------------------------------
	typedef struct packed {
		logic [8:0] rsv_hi;
		logic first_port_done;
		logic one_vector;
		logic context_faulted;
		logic rsv_lo;
		logic process_faulted;
		logic waiting_msg;
		logic unbound;
	} process_status_t;

	typedef struct packed {
		logic [7:0] processor_id;
		logic broadcast_accept;
		logic stopped;
		logic reference_mode;
		logic faulted;
		logic [3:0] processor_state;
	} processor_status_t;

	typedef struct packed {
		logic [11:0] rsv;
		logic interrupt_inhibit;
		logic [1:0] xack_delay;
		logic write_sample_delay;
	} periph_state_t;

	typedef struct packed {
		logic [7:0] rsv;
		logic [1:0] fault_level;
		logic receive_blocked;
		logic send_blocked;
		logic [3:0] completion;
	} function_state_t;

	typedef struct packed {
		logic [WORD_W-1:0] proc_sel;
		logic [WORD_W-1:0] opcode;
		logic [WORD_W-1:0] operand;
		logic [WORD_W-1:0] result;
	} func_request_t;

	typedef struct packed {
		logic done;
		logic send_blocked;
		logic receive_blocked;
		logic [1:0] fault_level;
		logic [WORD_W-1:0] result;
	} func_done_t;

endpackage : io_status_pkg

// ==== core/io_processor_status_fields.sv ====
// Status and control field bank of the I/O interface processor
`timescale 1ns/100ps
// ----------------------------------------
// Overview of operation
// - Unbound bit reads 0 when bound
// - Context and process faulted flags read 1
// - Process fault logged in process or processor
// - Rights bit 0 gates global broadcast
// - Rights bit 1 gates local message; bit 2 ignored
// - Copy refreshed on function or transfer completion
// - Window 4 exposes words above displacement four
// - Processor state idle 0000, executing 0001
// - Processor faulted flag reads 1 when faulted
// - Reference mode selects physical or logical operands
// - Stopped bit 0 running, 1 stopped
// - Broadcast accept bit shows acceptance
// - Processor ID loaded from straps at init
// - Interrupt inhibit masks only normal completions
// - Interface word holds delays and inhibit
// - Local and global response flags set on response
// - Alarm, dispatch, reconfiguration response flags
// - Request area five parts in order
// - Function state word field layout
// - Mapping and function engines run concurrently
// - Completion state done 0000, busy 0001
// - Send and receive bits 1 when blocked
// - Fault level none, context, process, processor
// - Request writes taken only when idle
// ----------------------------------------
module io_processor_status_fields
	import io_status_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Control window access (window 4), double-byte displacement
	input wire logic win_sel_i,
	input wire logic win_wr_i,
	input wire logic [WIN_DISP_W-1:0] win_disp_i,
	input wire logic [WORD_W-1:0] win_wdata_i,
	output logic [WORD_W-1:0] win_rdata_o,
	output logic win_hit_o,
	// External identity straps
	input wire logic [ID_W-1:0] processor_id_i,
	// Process binding and faults
	input wire logic bound_i,
	input wire logic waiting_msg_i,
	input wire logic one_vector_i,
	input wire logic first_port_done_i,
	input wire logic context_fault_i,
	input wire logic process_fault_i,
	input wire logic processor_fault_i,
	input wire logic stop_i,
	input wire logic broadcast_accept_i,
	input wire logic reference_mode_i,
	// Interprocessor signals and rights
	input wire logic [2:0] system_rights_i,
	input wire logic local_signal_i,
	input wire logic global_signal_i,
	input wire logic alarm_signal_i,
	input wire logic dispatch_signal_i,
	input wire logic reconf_signal_i,
	// Function engine handshake
	input wire io_status_pkg::func_done_t func_done_i,
	input wire logic block_xfer_done_i,
	output io_status_pkg::func_request_t func_req_o,
	output logic func_start_o,
	output logic logical_mode_o,
	output logic [ADDR_W-1:0] phys_operand_o,
	// Peripheral-side timing and host interrupt
	output logic write_sample_delay_o,
	output logic [1:0] xack_delay_o,
	output logic host_irq_o,
	output logic fault_in_process_area_o,
	output logic fault_in_processor_area_o,
	output logic mirror_refresh_o
);

	// ----------------------------------------
	// Synchronisers for pin inputs
	// ----------------------------------------
	localparam int NSYNC = 18;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	wire [NSYNC-1:0] raw_in = {bound_i, waiting_msg_i, one_vector_i, first_port_done_i,
		context_fault_i, process_fault_i, processor_fault_i, stop_i, broadcast_accept_i,
		reference_mode_i, system_rights_i, local_signal_i, global_signal_i, alarm_signal_i,
		dispatch_signal_i, reconf_signal_i};
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sync_a <= '0;
			sync_b <= '0;
		end
		else
		begin
			sync_a <= raw_in;
			sync_b <= sync_a;
		end
	end

	wire s_bound = sync_b[17];
	wire s_waiting = sync_b[16];
	wire s_one_vec = sync_b[15];
	wire s_first_done = sync_b[14];
	wire s_ctx_fault = sync_b[13];
	wire s_proc_fault = sync_b[12];
	wire s_cpu_fault = sync_b[11];
	wire s_stop = sync_b[10];
	wire s_bcast = sync_b[9];
	wire s_refmode = sync_b[8];
	wire [2:0] s_rights = sync_b[7:5];
	wire s_local = sync_b[4];
	wire s_global = sync_b[3];
	wire s_alarm = sync_b[2];
	wire s_dispatch = sync_b[1];
	wire s_reconf = sync_b[0];

	// Edge history so each signal answers once
	logic [4:0] sig_prev;
	wire [4:0] sig_now = {s_local, s_global, s_alarm, s_dispatch, s_reconf};
	wire [4:0] sig_rise = sig_now & ~sig_prev;
	// Rights bit 2 is deliberately never looked at
	wire local_ok = sig_rise[4] & s_rights[1];
	wire global_ok = sig_rise[3] & s_rights[0];

	// ----------------------------------------
	// Stored state
	// ----------------------------------------
	periph_state_t periph;
	function_state_t fstate;
	func_request_t freq;
	logic [ID_W-1:0] proc_id;
	logic id_loaded;
	logic [ID_W-1:0] id_sync_a;
	logic [ID_W-1:0] id_sync_b;
	logic [1:0] id_wait;
	localparam logic [1:0] ID_SETTLE = 2'h2;
	logic local_resp;
	logic global_resp;
	logic alarm_resp;
	logic dispatch_resp;
	logic reconf_resp;
	logic [3:0] pstate;

	typedef enum logic [1:0] {FN_IDLE, FN_START, FN_RUN} fn_state_t;
	fn_state_t fn;
	fn_state_t next_fn;

	// ----------------------------------------
	// Decode of control window
	// ----------------------------------------
	wire in_window = win_sel_i && (win_disp_i > CW_BASE);
	wire fn_busy = (fn != FN_IDLE);
	wire wr = in_window && win_wr_i;
	wire wr_req = wr && !fn_busy;
	wire wr_periph = wr && (win_disp_i == DISP_PERIPH_STATE);
	wire wr_sel = wr_req && (win_disp_i == DISP_PROC_SEL);
	wire wr_op = wr_req && (win_disp_i == DISP_OPCODE);
	wire wr_opnd = wr_req && (win_disp_i == DISP_OPERAND);
	// Writing the operand word launches the request
	wire launch = wr_opnd;

	process_status_t pstat_w;
	processor_status_t cstat_w;
	assign pstat_w = '{rsv_hi: '0, first_port_done: s_first_done, one_vector: s_one_vec,
		context_faulted: s_ctx_fault, rsv_lo: 1'b0, process_faulted: s_proc_fault,
		waiting_msg: s_waiting, unbound: !s_bound};
	assign cstat_w = '{processor_id: proc_id, broadcast_accept: s_bcast,
		stopped: s_stop, reference_mode: s_refmode,
		faulted: s_cpu_fault, processor_state: pstate};

	logic [WORD_W-1:0] next_rdata;
	always_comb
	begin
		case (win_disp_i)
			DISP_PROCESSOR_STATUS: next_rdata = cstat_w;
			DISP_PERIPH_STATE: next_rdata = periph;
			DISP_IPS_STATE: next_rdata = {14'h0000, global_resp, local_resp};
			DISP_ALARM_STATE: next_rdata = {15'h0000, alarm_resp};
			DISP_DISPATCH_STATE: next_rdata = {15'h0000, dispatch_resp};
			DISP_RECONF_STATE: next_rdata = {15'h0000, reconf_resp};
			DISP_PROC_SEL: next_rdata = freq.proc_sel;
			DISP_FUNC_STATE: next_rdata = fstate;
			DISP_OPCODE: next_rdata = freq.opcode;
			DISP_OPERAND: next_rdata = freq.operand;
			DISP_RESULT: next_rdata = freq.result;
			DISP_PROCESS_STATUS: next_rdata = pstat_w;
			default: next_rdata = RESET_WORD;
		endcase
	end

	// ----------------------------------------
	// Function request sequencer
	// ----------------------------------------
	always_comb
	begin
		case (fn)
			FN_IDLE: next_fn = launch ? FN_START : FN_IDLE;
			FN_START: next_fn = FN_RUN;
			FN_RUN: next_fn = func_done_i.done ? FN_IDLE : FN_RUN;
			default: next_fn = FN_IDLE;
		endcase
	end

	wire finishing = (fn == FN_RUN) && func_done_i.done;
	// Completions with a fault always interrupt, clean ones obey the inhibit
	wire clean_done = finishing && (func_done_i.fault_level == FLT_NONE);
	wire done_irq = finishing && (!clean_done || !periph.interrupt_inhibit);
	wire resp_irq = local_ok | global_ok | (|sig_rise[2:0]);

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			fn <= FN_IDLE;
			pstate <= PSTATE_IDLE;
			fstate <= RESET_WORD;
			freq <= '0;
		end
		else
		begin
			fn <= next_fn;
			if (launch)
			begin
				pstate <= PSTATE_EXEC;
				fstate.completion <= FCOMP_BUSY;
			end
			else if (finishing)
			begin
				pstate <= PSTATE_IDLE;
				fstate.completion <= FCOMP_DONE;
				fstate.send_blocked <= func_done_i.send_blocked;
				fstate.receive_blocked <= func_done_i.receive_blocked;
				fstate.fault_level <= func_done_i.fault_level;
				freq.result <= func_done_i.result;
			end
			if (wr_sel)
				freq.proc_sel <= win_wdata_i;
			if (wr_op)
				freq.opcode <= win_wdata_i;
			if (wr_opnd)
				freq.operand <= win_wdata_i;
		end
	end

	// ----------------------------------------
	// Interface word and responses
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			periph <= RESET_WORD;
			sig_prev <= '0;
			local_resp <= 1'b0;
			global_resp <= 1'b0;
			alarm_resp <= 1'b0;
			dispatch_resp <= 1'b0;
			reconf_resp <= 1'b0;
		end
		else
		begin
			sig_prev <= sig_now;
			if (wr_periph)
			begin
				periph <= win_wdata_i;
				periph.rsv <= '0;
			end
			// Flags are sticky: the host reads them, reset clears them
			if (local_ok)
				local_resp <= 1'b1;
			if (global_ok)
				global_resp <= 1'b1;
			if (sig_rise[2])
				alarm_resp <= 1'b1;
			if (sig_rise[1])
				dispatch_resp <= 1'b1;
			if (sig_rise[0])
				reconf_resp <= 1'b1;
		end
	end

	// ----------------------------------------
	// Identity strap capture
	// ----------------------------------------
	// Straps are pins: the synchroniser must fill before the load
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			id_sync_a <= '0;
			id_sync_b <= '0;
			id_wait <= '0;
			proc_id <= '0;
			id_loaded <= 1'b0;
		end
		else
		begin
			id_sync_a <= processor_id_i;
			id_sync_b <= id_sync_a;
			if (!id_loaded)
			begin
				if (id_wait == ID_SETTLE)
				begin
					proc_id <= id_sync_b;
					id_loaded <= 1'b1;
				end
				else
					id_wait <= id_wait + 2'h1;
			end
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			win_rdata_o <= RESET_WORD;
			win_hit_o <= 1'b0;
			func_req_o <= '0;
			func_start_o <= 1'b0;
			logical_mode_o <= 1'b0;
			phys_operand_o <= '0;
			write_sample_delay_o <= 1'b0;
			xack_delay_o <= '0;
			host_irq_o <= 1'b0;
			fault_in_process_area_o <= 1'b0;
			fault_in_processor_area_o <= 1'b0;
			mirror_refresh_o <= 1'b0;
		end
		else
		begin
			win_rdata_o <= in_window ? next_rdata : RESET_WORD;
			win_hit_o <= in_window;
			func_req_o <= freq;
			// Start is issued independently of mapping traffic
			func_start_o <= (fn == FN_START);
			logical_mode_o <= s_refmode;
			phys_operand_o <= {freq.proc_sel[ID_W-1:0], freq.operand};
			write_sample_delay_o <= periph.write_sample_delay;
			xack_delay_o <= periph.xack_delay;
			host_irq_o <= done_irq | resp_irq;
			fault_in_process_area_o <= s_proc_fault && s_bound;
			fault_in_processor_area_o <= s_proc_fault && !s_bound;
			mirror_refresh_o <= finishing | block_xfer_done_i;
		end
	end

endmodule : io_processor_status_fields

// ==== tb/io_status_chk.sv ====
// Port timing checker for the status field bank
`timescale 1ns/100ps
module io_status_chk
	import io_status_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic win_sel_i,
	input wire logic win_wr_i,
	input wire logic [WIN_DISP_W-1:0] win_disp_i,
	input wire logic [WORD_W-1:0] win_wdata_i,
	input wire logic [WORD_W-1:0] win_rdata_o,
	input wire logic win_hit_o,
	input wire io_status_pkg::func_done_t func_done_i,
	input wire logic block_xfer_done_i,
	input wire logic func_start_o,
	input wire logic [1:0] xack_delay_o,
	input wire logic host_irq_o,
	input wire logic fault_in_process_area_o,
	input wire logic fault_in_processor_area_o,
	input wire logic mirror_refresh_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	wire wr_if = win_sel_i && win_wr_i && win_disp_i == DISP_PERIPH_STATE;
	wire wr_op = win_sel_i && win_wr_i && win_disp_i == DISP_OPERAND;
	logic busy;
	logic [1:0] last_xack;
	// Busy spans start to done, so a second launch inside it is caught
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			busy <= 1'b0;
			last_xack <= 2'h0;
		end
		else
		begin
			busy <= (busy | func_start_o) & ~func_done_i.done;
			if (wr_if)
				last_xack <= win_wdata_i[2:1];
		end
	// ----
	// Assertions
	// ----
	a_low_disp_zero: assert property (
		win_sel_i && win_disp_i <= CW_BASE |=> win_rdata_o == 16'h0000 && !win_hit_o)
		else $error("low displacement read not zero");
	a_high_disp_hit: assert property (win_sel_i && win_disp_i > CW_BASE |=> win_hit_o)
		else $error("window access not flagged");
	a_start_cause: assert property (func_start_o |-> $past(wr_op, 2))
		else $error("start without operand write");
	a_no_restart: assert property (busy |-> !func_start_o)
		else $error("start while busy");
	a_fault_irq: assert property (
		func_done_i.done && func_done_i.fault_level != FLT_NONE |-> ##1 host_irq_o)
		else $error("faulted completion not interrupted");
	a_done_refresh: assert property (func_done_i.done |-> ##1 mirror_refresh_o)
		else $error("completion without refresh");
	a_xfer_refresh: assert property (block_xfer_done_i |-> ##[1:2] mirror_refresh_o)
		else $error("transfer end without refresh");
	a_fault_area: assert property (!(fault_in_process_area_o && fault_in_processor_area_o))
		else $error("both fault areas selected");
	a_xack_follow: assert property (!wr_if [*2] |-> xack_delay_o == last_xack)
		else $error("ack delay not from written word");
	c_start: cover property (func_start_o);
	c_irq: cover property (host_irq_o);
	c_hit: cover property (win_hit_o);
endmodule : io_status_chk

// ==== tb/func_engine_model.sv ====
// Behavioural model of the function engine behind the request port
`timescale 1ns/100ps
module func_engine_model
	import io_status_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic start_i,
	input wire io_status_pkg::func_request_t req_i,
	input wire logic [1:0] fault_i,
	input wire logic send_blocked_i,
	output io_status_pkg::func_done_t done_o
);
	int cnt;
	// Slow answer keeps the request busy long enough to probe it
	always @(posedge clk_sys_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			cnt <= 0;
			done_o <= '0;
		end
		else
		begin
			done_o.done <= (cnt == 1);
			done_o.fault_level <= fault_i;
			done_o.send_blocked <= send_blocked_i;
			done_o.receive_blocked <= 1'b0;
			// Result off the done cycle follows the countdown: it changes every cycle while counting and stays 0 when idle
			done_o.result <= (cnt == 1) ? ~req_i.operand : 16'(cnt);
			if (start_i)
				cnt <= 17;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
endmodule : func_engine_model

// ==== tb/testbench.sv ====
// Self-checking testbench of the status field bank
`timescale 1ns/100ps
module testbench;
	import io_status_pkg::*;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic win_sel_i = 1'b0;
	logic win_wr_i = 1'b0;
	logic [7:0] win_disp_i = 8'h00;
	logic [15:0] win_wdata_i = 16'h0000;
	logic [15:0] win_rdata_o;
	logic win_hit_o;
	logic [9:0] lv = 10'h000;
	logic [2:0] rights = 3'h0;
	logic [4:0] sig = 5'h00;
	logic xfer = 1'b0;
	logic [1:0] flt = 2'h0;
	logic sblk = 1'b0;
	logic inh = 1'b0;
	func_done_t fdone;
	func_request_t freq;
	logic fstart, lmode, wsd, irq, area_p, area_q, refresh;
	logic [1:0] xack;
	logic [23:0] phys;
	int mismatches = 0;
	int n_checks = 0;
	int irqs = 0;
	int refs = 0;
	int irq0 = 0;
	initial
		forever #12.5 clk_sys_i = ~clk_sys_i;
	io_processor_status_fields u_dut (.clk_sys_i, .reset_n_i, .win_sel_i, .win_wr_i,
		.win_disp_i, .win_wdata_i, .win_rdata_o, .win_hit_o, .processor_id_i(8'h5a),
		.bound_i(lv[0]), .waiting_msg_i(lv[1]), .one_vector_i(lv[2]),
		.first_port_done_i(lv[3]), .context_fault_i(lv[4]), .process_fault_i(lv[5]),
		.processor_fault_i(lv[6]), .stop_i(lv[7]), .broadcast_accept_i(lv[8]),
		.reference_mode_i(lv[9]), .system_rights_i(rights), .local_signal_i(sig[0]),
		.global_signal_i(sig[1]), .alarm_signal_i(sig[2]), .dispatch_signal_i(sig[3]),
		.reconf_signal_i(sig[4]), .func_done_i(fdone), .block_xfer_done_i(xfer),
		.func_req_o(freq), .func_start_o(fstart), .logical_mode_o(lmode),
		.phys_operand_o(phys), .write_sample_delay_o(wsd), .xack_delay_o(xack),
		.host_irq_o(irq), .fault_in_process_area_o(area_p),
		.fault_in_processor_area_o(area_q), .mirror_refresh_o(refresh));
	func_engine_model u_fe (.clk_sys_i, .reset_n_i, .start_i(fstart), .req_i(freq),
		.fault_i(flt), .send_blocked_i(sblk), .done_o(fdone));
	always @(posedge clk_sys_i)
	begin
		irqs <= irqs + irq;
		refs <= refs + refresh;
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic acc(input logic wr, input logic [7:0] d, input logic [15:0] v);
		@(negedge clk_sys_i);
		win_sel_i = 1'b1;
		win_wr_i = wr;
		win_disp_i = d;
		win_wdata_i = v;
		@(negedge clk_sys_i);
		win_sel_i = 1'b0;
	endtask : acc
	task automatic rd(input logic [7:0] d, input logic [15:0] exp, input string nm);
		acc(1'b0, d, 16'h0000);
		chk(nm, win_rdata_o, exp);
	endtask : rd
	task automatic func(input logic [1:0] f, input logic sb, input logic [15:0] op);
		int i0;
		int r0;
		int i;
		i0 = irqs;
		r0 = refs;
		flt = f;
		sblk = sb;
		acc(1'b1, DISP_PROC_SEL, 16'h0012);
		acc(1'b1, DISP_OPCODE, 16'h0003);
		acc(1'b1, DISP_OPERAND, op);
		xfer = 1'b1;
		@(negedge clk_sys_i);
		xfer = 1'b0;
		acc(1'b1, DISP_OPCODE, 16'h00ff);
		acc(1'b0, DISP_FUNC_STATE, 16'h0000);
		chk("busy state", win_rdata_o[3:0], FCOMP_BUSY);
		acc(1'b0, DISP_PROCESSOR_STATUS, 16'h0000);
		chk("exec state", win_rdata_o[3:0], PSTATE_EXEC);
		chk("operand", {lmode, phys}, {1'b0, 8'h12, op});
		chk("request copy", freq.opcode, 16'h0003);
		for (i = 0; i < 40 && win_rdata_o[3:0] !== FCOMP_DONE; i++)
			acc(1'b0, DISP_FUNC_STATE, 16'h0000);
		if (i == 40)
		begin
			mismatches++;
			results();
		end
		repeat (3) @(negedge clk_sys_i);
		rd(DISP_FUNC_STATE, {8'h00, f, 1'b0, sb, FCOMP_DONE}, "fstate");
		rd(DISP_OPCODE, 16'h0003, "opcode");
		rd(DISP_RESULT, ~op, "result");
		rd(DISP_PROCESSOR_STATUS, 16'h5a00, "idle state");
		chk("irq", irqs - i0, (f != FLT_NONE || !inh));
		chk("refresh", refs - r0, 2);
	endtask : func
	// ----
	// Main sequence
	// ----
	initial
	begin
		repeat (16) @(negedge clk_sys_i);
		reset_n_i = 1'b1;
		lv = 10'h3f0;
		repeat (5) @(negedge clk_sys_i);
		rd(DISP_PROCESS_STATUS, 16'h0015, "process status");
		rd(DISP_PROCESSOR_STATUS, 16'h5af0, "processor status");
		chk("logical mode", lmode, 1'b1);
		chk("fault area", {area_p, area_q}, 2'b01);
		lv = 10'h021;
		repeat (5) @(negedge clk_sys_i);
		chk("fault area", {area_p, area_q}, 2'b10);
		rd(DISP_PROCESS_STATUS, 16'h0004, "bound status");
		lv = 10'h001;
		repeat (5) @(negedge clk_sys_i);
		rd(CW_BASE, 16'h0000, "below window");
		acc(1'b1, DISP_PERIPH_STATE, 16'h0007);
		rd(DISP_PERIPH_STATE, 16'h0007, "interface");
		chk("delays", {xack, wsd}, 3'h7);
		func(FLT_NONE, 1'b1, 16'h3456);
		inh = 1'b1;
		acc(1'b1, DISP_PERIPH_STATE, 16'h0008);
		for (int f = 0; f < 4; f++)
			func(f[1:0], 1'b0, 16'h8001 + f[15:0]);
		irq0 = irqs;
		rights = 3'b101;
		for (int k = 0; k < 5; k++)
		begin
			sig = 5'h01 << k;
			repeat (4) @(negedge clk_sys_i);
			sig = 5'h00;
			repeat (4) @(negedge clk_sys_i);
		end
		chk("signal irqs", irqs - irq0, 4);
		rd(DISP_IPS_STATE, 16'h0002, "ipc global");
		rd(DISP_ALARM_STATE, 16'h0001, "alarm");
		rd(DISP_DISPATCH_STATE, 16'h0001, "dispatch");
		rd(DISP_RECONF_STATE, 16'h0001, "reconf");
		irq0 = irqs;
		rights = 3'b010;
		sig = 5'h01;
		repeat (4) @(negedge clk_sys_i);
		sig = 5'h00;
		repeat (4) @(negedge clk_sys_i);
		chk("local irq", irqs - irq0, 1);
		rd(DISP_IPS_STATE, 16'h0003, "ipc local");
		results();
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		mismatches++;
		results();
	end
endmodule : testbench
bind io_processor_status_fields io_status_chk u_chk (.clk_sys_i, .reset_n_i, .win_sel_i,
	.win_wr_i, .win_disp_i, .win_wdata_i, .win_rdata_o, .win_hit_o, .func_done_i,
	.block_xfer_done_i, .func_start_o, .xack_delay_o, .host_irq_o, .fault_in_process_area_o,
	.fault_in_processor_area_o, .mirror_refresh_o);
